// file: src/cmd_defs.vh
// Purpose: shared constants of the reference-search and output command block
// Assumes: 32-bit AHB-Lite register words, one aligned word per register
// Notes:   offsets are byte addresses
`ifndef CMD_DEFS_VH
`define CMD_DEFS_VH

// register byte offsets
`define OFS_CMD_HEAD     8'h00
`define OFS_CMD_VALUE    8'h04
`define OFS_CMD_SUM      8'h08
`define OFS_REPLY_HEAD   8'h0c
`define OFS_REPLY_VALUE  8'h10
`define OFS_REPLY_SUM    8'h14
`define OFS_STATUS       8'h18
`define OFS_CONFIG       8'h1c
`define OFS_ACCUM        8'h20
`define OFS_LINES        8'h24

// status register bit positions
`define ST_REPLY_READY   0
`define ST_REF_ACTIVE    1
`define ST_SUM_ERROR     2
`define ST_IGNORED       3

// config register fields: module address in [7:0], host address in [15:8]
`define CFG_MOD_LSB      0
`define CFG_HOST_LSB     8
`define RST_MOD_ADDR     8'h01
`define RST_HOST_ADDR    8'h02

// instruction numbers and selectors
`define INSTR_REF_SEARCH 8'h0d
`define INSTR_SET_OUTPUT 8'h0e
`define SEARCH_START     8'h00
`define SEARCH_STOP      8'h01
`define SEARCH_QUERY     8'h02
`define BANK_PULLUP      8'h00
`define BANK_GP_OUT      8'h02
`define PORT_ALL         8'hff
`define VALUE_FROM_ACCUM 32'hffffffff

// reply status codes
`define STAT_OK          8'h64
`define STAT_BAD_SUM     8'h01
`define STAT_BAD_CMD     8'h02
`define STAT_BAD_TYPE    8'h03
`define STAT_BAD_VALUE   8'h04

// reset values of the outputs
`define RST_PULLUP       3'h7
`define RST_GP_OUT       8'h00

`endif

// file: src/ref_search_fsm.v
// Purpose: start/stop control of the reference search
// Assumes: home_hit is already synchronised to hclk
// Notes:   the motion algorithm itself lives outside; this only tracks it
`timescale 1ns/1ps
`default_nettype none

module ref_search_fsm (
    // clock and reset
    input  wire       hclk,
    input  wire       hresetn,
    // control pulses
    input  wire       start,
    input  wire       stop,
    input  wire       home_hit,
    // state
    output wire       active,
    output reg  [1:0] state
);
    localparam [1:0] S_IDLE = 2'h1;
    localparam [1:0] S_SEEK = 2'h2;

    reg [1:0] next_state;

    // stop has priority over a start in the same cycle
    always @* begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (start && !stop) begin
                    next_state = S_SEEK;
                end
            end
            S_SEEK: begin
                if (stop || home_hit) begin
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign active = (state == S_SEEK);
endmodule // ref_search_fsm

`default_nettype wire

// file: src/ref_search_and_output_cmd.v
// Purpose: decode and execute reference-search and set-output command frames
// Assumes: software loads a nine-byte frame into three registers over AHB-Lite
// Notes:   writing the checksum register executes the frame one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "cmd_defs.vh"

module ref_search_and_output_cmd #(
    parameter GP_OUT_W = 8
) (
    // ahb-lite slave
    input  wire                hclk,
    input  wire                hresetn,
    input  wire                hsel,
    input  wire [31:0]         haddr,
    input  wire [1:0]          htrans,
    input  wire                hwrite,
    input  wire [2:0]          hsize,
    input  wire [31:0]         hwdata,
    input  wire                hready,
    output wire                hreadyout,
    output wire                hresp,
    output reg  [31:0]         hrdata,
    // reference search link to the motion engine
    input  wire                ref_home_hit,
    output wire                ref_search_run,
    // digital lines
    output reg  [GP_OUT_W-1:0] gp_out,
    output reg  [2:0]          pullup_en
);
    // modulo-256 sum of eight bytes; carries wrap silently, which is the rule
    function [7:0] sum8;
        input [63:0] b;
        begin
            sum8 = b[63:56] + b[55:48] + b[47:40] + b[39:32]
                 + b[31:24] + b[23:16] + b[15:8] + b[7:0];
        end
    endfunction

    // register map, one aligned word each, byte offsets:
    //   00 command head {target, instruction, type, bank}
    //   04 command value, most significant byte first
    //   08 command checksum in [7:0]; writing it runs the frame
    //   0c reply head {host, target, status, instruction}
    //   10 reply value
    //   14 reply checksum in [7:0]
    //   18 status: reply ready, search active, sum error, ignored
    //   1c config: module address [7:0], host address [15:8]
    //   20 accumulator, source of the all-outputs update with value -1
    //   24 lines: outputs [7:0], pull-ups [18:16]
    // the three sticky status flags clear by writing ones
    // command and reply storage
    reg  [31:0] cmd_head;
    reg  [31:0] cmd_value;
    reg  [7:0]  cmd_sum;
    reg  [31:0] reply_head;
    reg  [31:0] reply_value;
    reg  [7:0]  reply_sum;
    reg  [31:0] accum;
    reg  [7:0]  mod_addr;
    reg  [7:0]  host_addr;
    reg         reply_ready;
    reg         sum_error;
    reg         ignored;
    reg         exec;

    // ahb address phase capture
    reg         wr_pend;
    reg  [7:0]  wr_addr;
    wire        take = hsel && htrans[1] && hready;

    // home pin synchroniser; only the second stage is read
    reg         home_meta;
    reg         home_sync;

    // frame fields
    wire [7:0]  f_target = cmd_head[31:24];
    wire [7:0]  f_instr  = cmd_head[23:16];
    wire [7:0]  f_type   = cmd_head[15:8];
    wire [7:0]  f_bank   = cmd_head[7:0];
    wire        sum_ok   = (sum8({cmd_head, cmd_value}) == cmd_sum);
    wire        for_us   = (f_target == mod_addr);

    // search state machine
    wire        search_active;
    wire [1:0]  search_state;
    reg         do_start;
    reg         do_stop;

    // decoder results
    reg  [7:0]          next_status;
    reg  [31:0]         next_value;
    reg  [GP_OUT_W-1:0] next_gp_out;
    reg  [2:0]          next_pullup;
    wire [31:0]         next_reply_head = {host_addr, f_target, next_status, f_instr};
    wire [63:0]         reply_bytes = {next_reply_head, next_value};

    // zero wait states: every register answers in the data phase, and the
    // read mux over flip-flops keeps a write of the previous phase visible
    assign hreadyout = 1'b1; // every access completes with no wait state
    assign hresp     = 1'b0;
    assign ref_search_run = search_active;

    ref_search_fsm u_search (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .start    (do_start),
        .stop     (do_stop),
        .home_hit (home_sync),
        .active   (search_active),
        .state    (search_state)
    );

    // errors fall through with outputs unchanged and a status naming the fault
    // command decode: only a frame with a good sum can move the outputs or the search
    always @* begin
        next_status = `STAT_OK;
        next_value  = 32'h00000000;
        next_gp_out = gp_out;
        next_pullup = pullup_en;
        do_start    = 1'b0;
        do_stop     = 1'b0;
        if (!sum_ok) begin
            next_status = `STAT_BAD_SUM;
        end else begin
            case (f_instr)
                `INSTR_REF_SEARCH: begin
                    if (f_bank != 8'h00) begin
                        next_status = `STAT_BAD_VALUE;
                    end else if (f_type == `SEARCH_START) begin
                        do_start = exec;
                    end else if (f_type == `SEARCH_STOP) begin
                        do_stop = exec;
                    end else if (f_type == `SEARCH_QUERY) begin
                        // a query reads the machine but never drives start or stop
                        // the state code is never zero, so active reads non-zero
                        next_value = search_active ? {30'h0, search_state} : 32'h0;
                    end else begin
                        next_status = `STAT_BAD_TYPE;
                    end
                end
                `INSTR_SET_OUTPUT: begin
                    if (f_bank == `BANK_GP_OUT) begin
                        if (f_type == `PORT_ALL) begin
                            if (cmd_value == `VALUE_FROM_ACCUM) begin
                                next_gp_out = accum[GP_OUT_W-1:0];
                            end else if (cmd_value[31:8] == 24'h0) begin
                                next_gp_out = cmd_value[GP_OUT_W-1:0];
                            end else begin
                                next_status = `STAT_BAD_VALUE;
                            end
                        end else if (f_type < 8'h02) begin
                            if (cmd_value[31:1] == 31'h0) begin
                                next_gp_out[f_type[0]] = cmd_value[0];
                            end else begin
                                next_status = `STAT_BAD_VALUE;
                            end
                        end else begin
                            next_status = `STAT_BAD_TYPE;
                        end
                    end else if (f_bank == `BANK_PULLUP) begin
                        if (f_type != 8'h00) begin
                            next_status = `STAT_BAD_TYPE;
                        end else if (cmd_value[31:3] == 29'h0) begin
                            next_pullup = cmd_value[2:0];
                        end else begin
                            next_status = `STAT_BAD_VALUE;
                        end
                    end else begin
                        next_status = `STAT_BAD_VALUE;
                    end
                end
                default: next_status = `STAT_BAD_CMD;
            endcase
        end
        // frames for another address cannot start or stop the search; setting the ignored flag is their only effect
        if (!for_us) begin
            do_start = 1'b0;
            do_stop  = 1'b0;
        end
    end

    // pin synchroniser; the home pin is asynchronous to hclk
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            home_meta <= 1'b0;
            home_sync <= 1'b0;
        end else begin
            home_meta <= ref_home_hit;
            home_sync <= home_meta;
        end
    end

    // ahb address phase, write data taken in the following data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= take && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // register writes, frame execution and sticky status
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_head    <= 32'h00000000;
            cmd_value   <= 32'h00000000;
            cmd_sum     <= 8'h00;
            reply_head  <= 32'h00000000;
            reply_value <= 32'h00000000;
            reply_sum   <= 8'h00;
            accum       <= 32'h00000000;
            mod_addr    <= `RST_MOD_ADDR;
            host_addr   <= `RST_HOST_ADDR;
            reply_ready <= 1'b0;
            sum_error   <= 1'b0;
            ignored     <= 1'b0;
            exec        <= 1'b0;
            gp_out      <= `RST_GP_OUT;
            pullup_en   <= `RST_PULLUP;
        end else begin
            // exec waits one cycle so the sum byte already sits in its flip-flop
            exec <= wr_pend && (wr_addr == `OFS_CMD_SUM);
            if (wr_pend) begin
                case (wr_addr)
                    `OFS_CMD_HEAD:  cmd_head  <= hwdata;
                    `OFS_CMD_VALUE: cmd_value <= hwdata;
                    `OFS_CMD_SUM:   cmd_sum   <= hwdata[7:0];
                    `OFS_ACCUM:     accum     <= hwdata;
                    `OFS_CONFIG: begin
                        mod_addr  <= hwdata[`CFG_MOD_LSB+7:`CFG_MOD_LSB];
                        host_addr <= hwdata[`CFG_HOST_LSB+7:`CFG_HOST_LSB];
                    end
                    `OFS_STATUS: begin
                        // write one to clear; a same-cycle set below wins
                        if (hwdata[`ST_REPLY_READY]) reply_ready <= 1'b0;
                        if (hwdata[`ST_SUM_ERROR])   sum_error   <= 1'b0;
                        if (hwdata[`ST_IGNORED])     ignored     <= 1'b0;
                    end
                    default: ;
                endcase
            end
            if (exec) begin
                if (!for_us) begin
                    ignored <= 1'b1;
                end else begin
                    gp_out      <= next_gp_out;
                    pullup_en   <= next_pullup;
                    reply_head  <= next_reply_head;
                    reply_value <= next_value;
                    reply_sum   <= sum8(reply_bytes);
                    reply_ready <= 1'b1;
                    if (!sum_ok) sum_error <= 1'b1;
                end
            end
        end
    end

    // output lines padded or cut to one byte for read-back
    wire [7:0] gp_out_word;

    // read mux over flip-flops; unmapped words read zero
    always @* begin
        case (wr_addr)
            `OFS_CMD_HEAD:    hrdata = cmd_head;
            `OFS_CMD_VALUE:   hrdata = cmd_value;
            `OFS_CMD_SUM:     hrdata = {24'h0, cmd_sum};
            `OFS_REPLY_HEAD:  hrdata = reply_head;
            `OFS_REPLY_VALUE: hrdata = reply_value;
            `OFS_REPLY_SUM:   hrdata = {24'h0, reply_sum};
            `OFS_STATUS:      hrdata = {28'h0, ignored, sum_error, search_active, reply_ready};
            `OFS_CONFIG:      hrdata = {16'h0, host_addr, mod_addr};
            `OFS_ACCUM:       hrdata = accum;
            `OFS_LINES:       hrdata = {13'h0, pullup_en, 8'h0, gp_out_word};
            default:          hrdata = 32'h00000000;
        endcase
    end

    // narrow builds pad the read-back byte with zeros
    generate
        if (GP_OUT_W >= 8) begin : g_wide
            assign gp_out_word = gp_out[7:0];
        end else begin : g_narrow
            assign gp_out_word = {{(8-GP_OUT_W){1'b0}}, gp_out};
        end
    endgenerate
endmodule // ref_search_and_output_cmd

`default_nettype wire

// file: bench/ref_search_and_output_cmd_properties.sv
// Purpose: bus-side checks of the command block
// Assumes: zero-wait slave, a frame takes effect two edges after its sum write
// Notes:   sees only the top ports, bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
`include "cmd_defs.vh"
module ref_search_and_output_cmd_properties #(
    parameter GP_OUT_W = 8
) (
    // ahb-lite side
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [2:0]          hsize,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic [31:0]         hrdata,
    // search link and lines
    input wire logic                ref_home_hit,
    input wire logic                ref_search_run,
    input wire logic [GP_OUT_W-1:0] gp_out,
    input wire logic [2:0]          pullup_en
);
    logic dp_sum;
    logic dp_lines;
    logic dp_stat;
    logic dp_free;
    wire  take = hsel & htrans[1] & hready;
    // note what the running data phase belongs to, outputs may only move after a sum write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_sum   <= 1'b0;
            dp_lines <= 1'b0;
            dp_stat  <= 1'b0;
            dp_free  <= 1'b0;
        end else if (hready) begin
            dp_sum   <= take & hwrite & (haddr[7:0] == `OFS_CMD_SUM);
            dp_lines <= take & !hwrite & (haddr[7:0] == `OFS_LINES);
            dp_stat  <= take & !hwrite & (haddr[7:0] == `OFS_STATUS);
            dp_free  <= take & !hwrite & (haddr[7:0] == 8'h3c);
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered with an error");
    a_reset_state: assert property (!$past(hresetn) |-> pullup_en == 3'h7 && gp_out == '0)
        else $error("outputs wrong right after reset");
    a_gp_cause: assert property ($changed(gp_out) |-> $past(dp_sum, 2))
        else $error("outputs moved without a frame");
    a_pull_cause: assert property ($changed(pullup_en) |-> $past(dp_sum, 2))
        else $error("pull-ups moved without a frame");
    a_run_start: assert property ($rose(ref_search_run) |-> $past(dp_sum, 2) || $past(dp_sum, 3))
        else $error("search started without a frame");
    a_lines_view: assert property (dp_lines |-> hrdata[7:0] == gp_out[7:0] && hrdata[18:16] == pullup_en)
        else $error("line readback differs from outputs");
    a_status_run: assert property (dp_stat |-> hrdata[`ST_REF_ACTIVE] == ref_search_run)
        else $error("search flag differs from run output");
    a_free_zero: assert property (dp_free |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    c_sum_write: cover property (dp_sum);
    c_search: cover property ($rose(ref_search_run));
    c_pullup: cover property ($changed(pullup_en));
endmodule // ref_search_and_output_cmd_properties
`default_nettype wire

// file: bench/motion_engine_model.sv
// Purpose: motion-engine stand-in that reports the home switch
// Assumes: home_delay of 0 means the switch is never found
// Notes:   the flag stays up until the search drops, as a real switch would
`timescale 1ns/1ps
`default_nettype none
module motion_engine_model (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // search link
    input  wire logic       ref_search_run,
    input  wire logic [7:0] home_delay,
    output var  logic       ref_home_hit
);
    logic [7:0] run_cnt;
    // count travel cycles, saturating so a long search never wraps into a false hit
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_cnt      <= 8'h00;
            ref_home_hit <= 1'b0;
        end else if (!ref_search_run) begin
            run_cnt      <= 8'h00;
            ref_home_hit <= 1'b0;
        end else begin
            if (run_cnt != 8'hff) begin
                run_cnt <= run_cnt + 8'h01;
            end
            ref_home_hit <= (home_delay != 8'h00) && (run_cnt >= home_delay);
        end
    end
endmodule // motion_engine_model
`default_nettype wire

// file: bench/ref_search_and_output_cmd_bench.sv
// Purpose: frame-level tests of the command block over ahb-lite
// Assumes: module address 1, host address 2 as after reset
// Notes:   every wait is bounded, the design answers with no wait states
`timescale 1ns/1ps
`default_nettype none
`include "cmd_defs.vh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); num_errors++; end end
module ref_search_and_output_cmd_bench;
    localparam GP_OUT_W = 8;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic [7:0]  home_delay = 8'h00;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    wire         ref_search_run;
    wire         ref_home_hit;
    wire  [7:0]  gp_out;
    wire  [2:0]  pullup_en;
    int          num_errors = 0;
    int          samples_checked = 0;
    logic [31:0] d;
    always #2.5 hclk = ~hclk;
    ref_search_and_output_cmd #(.GP_OUT_W(GP_OUT_W)) ref_search_and_output_cmd_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ref_home_hit(ref_home_hit),
        .ref_search_run(ref_search_run), .gp_out(gp_out), .pullup_en(pullup_en));
    motion_engine_model motion_engine_model_i (.hclk(hclk), .hresetn(hresetn),
        .ref_search_run(ref_search_run), .home_delay(home_delay), .ref_home_hit(ref_home_hit));
    task automatic print_verdict();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one single ahb transfer; hready is the slave's own, still waited on with a bound
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd_v);
        int n;
        bit late;
        n = 0;
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do begin @(posedge hclk); n++; end while (hready_ok() == 0 && n < 16);
        late = (hready_ok() == 0);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? wd : 32'h0;
        do begin @(posedge hclk); n++; end while (hready_ok() == 0 && n < 32);
        rd_v = hrdata;
        if (late || hready_ok() == 0) begin
            num_errors++;
            print_verdict();
        end
    endtask
    function automatic bit hready_ok();
        return hreadyout === 1'b1;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        xfer(1'b1, a, v, x);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        xfer(1'b0, a, 32'h0, v);
    endtask
    function automatic logic [7:0] bsum(input logic [63:0] b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 8; i++) begin
            s += b[8*i +: 8];
        end
        return s;
    endfunction
    // send one frame to module 1, bad spoils the checksum, then check the whole reply
    task automatic cmd(input logic [7:0] ins, typ, bnk, input logic [31:0] v,
                       input logic [7:0] st, input logic [31:0] rv, input logic [7:0] bad);
        logic [31:0] r;
        wr(`OFS_CMD_HEAD, {8'h01, ins, typ, bnk});
        wr(`OFS_CMD_VALUE, v);
        wr(`OFS_CMD_SUM, {24'h0, bsum({8'h01, ins, typ, bnk, v}) + bad});
        rd(`OFS_REPLY_HEAD, r);
        `CHK("reply head", {8'h02, 8'h01, st, ins}, r)
        rd(`OFS_REPLY_VALUE, r);
        `CHK("reply value", rv, r)
        rd(`OFS_REPLY_SUM, r);
        `CHK("reply sum", {24'h0, bsum({8'h02, 8'h01, st, ins, rv})}, r)
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        `CHK("pullups", 3'h7, pullup_en)
        `CHK("outputs", 8'h00, gp_out)
        rd(8'h3c, d);
        `CHK("unmapped", 32'h0, d)
        cmd(`INSTR_SET_OUTPUT, 8'h00, `BANK_GP_OUT, 32'h1, `STAT_OK, 32'h0, 8'h0);
        `CHK("out zero", 8'h01, gp_out)
        cmd(`INSTR_SET_OUTPUT, 8'h01, `BANK_GP_OUT, 32'h1, `STAT_OK, 32'h0, 8'h0);
        `CHK("out one", 8'h03, gp_out)
        cmd(`INSTR_SET_OUTPUT, 8'h00, `BANK_GP_OUT, 32'h0, `STAT_OK, 32'h0, 8'h0);
        `CHK("out zero low", 8'h02, gp_out)
        cmd(`INSTR_SET_OUTPUT, 8'h01, `BANK_GP_OUT, 32'h2, `STAT_BAD_VALUE, 32'h0, 8'h0);
        `CHK("bad value kept", 8'h02, gp_out)
        cmd(`INSTR_SET_OUTPUT, `PORT_ALL, `BANK_GP_OUT, 32'ha5, `STAT_OK, 32'h0, 8'h0);
        `CHK("all outputs", 8'ha5, gp_out)
        cmd(`INSTR_SET_OUTPUT, `PORT_ALL, `BANK_GP_OUT, 32'hff, `STAT_OK, 32'h0, 8'h0);
        `CHK("all outputs max", 8'hff, gp_out)
        wr(`OFS_ACCUM, 32'h1234563c);
        cmd(`INSTR_SET_OUTPUT, `PORT_ALL, `BANK_GP_OUT, 32'hffffffff, `STAT_OK, 32'h0, 8'h0);
        `CHK("from accumulator", 8'h3c, gp_out)
        for (int v = 0; v < 8; v++) begin
            cmd(`INSTR_SET_OUTPUT, 8'h00, `BANK_PULLUP, v, `STAT_OK, 32'h0, 8'h0);
            `CHK("pullup vector", v[2:0], pullup_en)
        end
        cmd(`INSTR_SET_OUTPUT, 8'h00, `BANK_PULLUP, 32'h8, `STAT_BAD_VALUE, 32'h0, 8'h0);
        `CHK("pullup kept", 3'h7, pullup_en)
        rd(`OFS_LINES, d);
        `CHK("line readback", {13'h0, 3'h7, 8'h0, 8'h3c}, d)
        cmd(`INSTR_SET_OUTPUT, 8'h00, `BANK_GP_OUT, 32'h1, `STAT_BAD_SUM, 32'h0, 8'h01);
        `CHK("bad sum kept", 8'h3c, gp_out)
        rd(`OFS_STATUS, d);
        `CHK("sum error flag", 4'h5, d[3:0])
        wr(`OFS_STATUS, 32'hf);
        wr(`OFS_CMD_HEAD, {8'h03, `INSTR_SET_OUTPUT, 8'h00, `BANK_GP_OUT});
        wr(`OFS_CMD_VALUE, 32'h1);
        wr(`OFS_CMD_SUM, {24'h0, bsum({8'h03, `INSTR_SET_OUTPUT, 8'h00, `BANK_GP_OUT, 32'h1})});
        rd(`OFS_STATUS, d);
        `CHK("foreign frame flag", 4'h8, d[3:0])
        `CHK("foreign frame kept", 8'h3c, gp_out)
        cmd(`INSTR_SET_OUTPUT, `PORT_ALL, `BANK_GP_OUT, 32'h100, `STAT_BAD_VALUE, 32'h0, 8'h0);
        `CHK("wide vector kept", 8'h3c, gp_out)
        cmd(8'h0f, 8'h00, 8'h00, 32'h0, `STAT_BAD_CMD, 32'h0, 8'h0);
        cmd(`INSTR_REF_SEARCH, 8'h03, 8'h00, 32'h0, `STAT_BAD_TYPE, 32'h0, 8'h0);
        `CHK("bad type idle", 1'b0, ref_search_run)
        cmd(`INSTR_REF_SEARCH, 8'h00, 8'h00, 32'h0, `STAT_OK, 32'h0, 8'h0);
        `CHK("search started", 1'b1, ref_search_run)
        rd(`OFS_STATUS, d);
        `CHK("search flag", 1'b1, d[`ST_REF_ACTIVE])
        cmd(`INSTR_REF_SEARCH, 8'h02, 8'h00, 32'h0, `STAT_OK, 32'h2, 8'h0);
        `CHK("query keeps search", 1'b1, ref_search_run)
        cmd(`INSTR_REF_SEARCH, 8'h01, 8'h00, 32'h0, `STAT_OK, 32'h0, 8'h0);
        `CHK("search stopped", 1'b0, ref_search_run)
        cmd(`INSTR_REF_SEARCH, 8'h02, 8'h00, 32'h0, `STAT_OK, 32'h0, 8'h0);
        cmd(`INSTR_REF_SEARCH, 8'h00, 8'h01, 32'h0, `STAT_BAD_VALUE, 32'h0, 8'h0);
        `CHK("wrong motor refused", 1'b0, ref_search_run)
        home_delay <= 8'h06;
        cmd(`INSTR_REF_SEARCH, 8'h00, 8'h00, 32'h0, `STAT_OK, 32'h0, 8'h0);
        for (int i = 0; i < 40 && ref_search_run === 1'b1; i++) @(posedge hclk);
        `CHK("home ends search", 1'b0, ref_search_run)
        print_verdict();
    end
endmodule // ref_search_and_output_cmd_bench
bind ref_search_and_output_cmd ref_search_and_output_cmd_properties #(.GP_OUT_W(GP_OUT_W)) props_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ref_home_hit(ref_home_hit),
    .ref_search_run(ref_search_run), .gp_out(gp_out), .pullup_en(pullup_en));
`default_nettype wire
